// >>> design/sas_map.svh
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// ------------------------------------------------------------
// register indexes: byte address is four times the index
// ------------------------------------------------------------
`define SAS_MODE_IDX 8'hBD
`define SAS_RES_HI_IDX 8'hBE
`define SAS_RES_LO_IDX 8'hBF
`define SAS_EV_STAT_IDX 8'hC0
`define SAS_EV_EN_IDX 8'hC1
`define SAS_EV_CLR_IDX 8'hC2

// ------------------------------------------------------------
// mode register layout and reset values
// ------------------------------------------------------------
`define SAS_MODE_RST 8'h00
`define SAS_START_BIT 7
`define SAS_DONE_BIT 6
`define SAS_CLK_MSB 5
`define SAS_CLK_LSB 4
`define SAS_CHAN_MSB 3
`define SAS_CHAN_LSB 0
`define SAS_CHAN_BANDGAP 4'hF
`define SAS_CHAN_EXT_TOP 4'h8
`define SAS_CHAN_FOURTEEN 4'hE

// ------------------------------------------------------------
// event bits: done, aborted, clock too fast
// ------------------------------------------------------------
`define SAS_EV_W 3
`define SAS_EV_DONE 0
`define SAS_EV_ABORT 1
`define SAS_EV_FAST 2

// ------------------------------------------------------------
// conversion timing in converter clocks; analog minimum in ns and system clocks
// ------------------------------------------------------------
`define SAS_RES_BITS 12
`define SAS_SETUP_CLKS 7'd10
`define SAS_BIT_CLKS 7'd4
`define SAS_TOTAL_CLKS 7'd66
`define SAS_TAIL_CLKS (`SAS_TOTAL_CLKS - `SAS_SETUP_CLKS - 7'd12 * `SAS_BIT_CLKS)
`define SAS_MIN_CONV_NS 25000
`define SAS_REF_PERIOD_NS 50
`define SAS_MIN_CONV_CYC ((`SAS_MIN_CONV_NS + `SAS_REF_PERIOD_NS - 1) / `SAS_REF_PERIOD_NS)

`endif

// >>> design/sas_pkg.sv
package sas_pkg;
	// sequencer states, one-hot
	typedef enum logic [3:0] {
		SAS_IDLE = 4'b0001,
		SAS_SETUP = 4'b0010,
		SAS_CONV = 4'b0100,
		SAS_TAIL = 4'b1000
	} sas_seq_state_t;

	typedef logic [3:0] sas_chan_t;
	typedef logic [1:0] sas_clk_sel_t;

	// codes that reach an external analog pin
	function automatic logic sas_chan_ext(input sas_chan_t c);
		sas_chan_ext = (c <= 4'h8) || (c == 4'hE);
	endfunction
endpackage

// >>> design/sas_sar_seq.sv
`timescale 1ns/1ns
`include "sas_map.svh"

module sas_sar_seq #(
	parameter int RES_W = `SAS_RES_BITS
) (
	input wire logic ref_clk_i, // system clock
	input wire logic rst_i, // async reset, high
	input wire logic tick_i, // converter clock enable pulse
	input wire logic start_i, // begin conversion
	input wire logic abort_i, // stop conversion
	input wire logic comp_i, // comparator: input above dac
	output logic busy_o, // conversion running
	output logic done_o, // one-cycle completion pulse
	output logic [RES_W-1:0] sar_o, // resolved bits
	output logic [RES_W-1:0] dac_code_o // trial code to dac
);
	import sas_pkg::*;

	if (RES_W < 2 || RES_W > 16 || 32'(`SAS_SETUP_CLKS) +
	    RES_W * 32'(`SAS_BIT_CLKS) > 32'(`SAS_TOTAL_CLKS)) begin : g_bad
		$error("sas_sar_seq: unsupported RES_W");
	end

	sas_seq_state_t state_r;
	logic [6:0] cnt_r;
	logic [3:0] idx_r;
	logic [RES_W-1:0] sar_r;
	logic [RES_W-1:0] dac_r;
	logic done_r;
	logic [RES_W-1:0] keep;

	function automatic logic [RES_W-1:0] bit_at(input logic [3:0] i);
		bit_at = '0;
		bit_at[i] = 1'b1;
	endfunction

	// comparator decision on the bit under trial
	assign keep = sar_r | (comp_i ? bit_at(idx_r) : '0);

	// ------------------------------------------------------------
	// sequencer: setup, one 4-clock step per bit, tail
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= SAS_IDLE;
			cnt_r <= 7'd0;
			idx_r <= 4'd0;
			sar_r <= '0;
			dac_r <= '0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			unique case (state_r)
				SAS_IDLE: begin
					if (start_i) begin
						state_r <= SAS_SETUP;
						cnt_r <= 7'd0;
						sar_r <= '0;
						dac_r <= '0;
					end
				end
				SAS_SETUP: begin
					if (abort_i) begin
						state_r <= SAS_IDLE;
					end else if (tick_i) begin
						if (cnt_r == `SAS_SETUP_CLKS - 7'd1) begin
							state_r <= SAS_CONV;
							cnt_r <= 7'd0;
							idx_r <= 4'(RES_W - 1);
							dac_r <= bit_at(4'(RES_W - 1)); // half scale first
						end else begin
							cnt_r <= cnt_r + 7'd1;
						end
					end
				end
				SAS_CONV: begin
					if (abort_i) begin
						state_r <= SAS_IDLE;
					end else if (tick_i) begin
						if (cnt_r == `SAS_BIT_CLKS - 7'd1) begin
							cnt_r <= 7'd0;
							sar_r <= keep;
							if (idx_r == 4'd0) begin
								state_r <= SAS_TAIL;
								dac_r <= keep;
							end else begin
								idx_r <= idx_r - 4'd1;
								dac_r <= keep | bit_at(idx_r - 4'd1);
							end
						end else begin
							cnt_r <= cnt_r + 7'd1;
						end
					end
				end
				SAS_TAIL: begin
					if (abort_i) begin
						state_r <= SAS_IDLE;
					end else if (tick_i) begin
						if (cnt_r == `SAS_TAIL_CLKS - 7'd1) begin
							state_r <= SAS_IDLE;
							done_r <= 1'b1;
						end else begin
							cnt_r <= cnt_r + 7'd1;
						end
					end
				end
			endcase
		end
	end

	assign busy_o = (state_r != SAS_IDLE);
	assign done_o = done_r;
	assign sar_o = sar_r;
	assign dac_code_o = dac_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [7:0] tk_r; // ticks seen since start, checking only
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tk_r <= 8'd0;
		end else if (start_i && !busy_o) begin
			tk_r <= 8'd0;
		end else if (tick_i && busy_o) begin
			tk_r <= tk_r + 8'd1;
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	property p_total_clks;
		done_o |-> tk_r == 8'(`SAS_TOTAL_CLKS);
	endproperty
	a_total_clks: assert property (p_total_clks)
		else $error("conversion did not take the full clock count");

	property p_msb_first;
		$rose(state_r == SAS_CONV) |-> dac_r == bit_at(4'(RES_W - 1));
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("first trial is not the top bit");
endmodule // sas_sar_seq

// >>> design/sas_adc_ctrl.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
`include "sas_map.svh"

module sas_adc_ctrl #(
	parameter int RES_W = `SAS_RES_BITS,
	parameter int AW = 10
) (
	input wire logic ref_clk_i, // system clock
	input wire logic rst_i, // async reset, high
	input wire logic hsel_i, // ahb select
	input wire logic [AW-1:0] haddr_i, // ahb byte address
	input wire logic hwrite_i, // ahb write
	input wire logic [1:0] htrans_i, // ahb transfer type
	input wire logic [2:0] hsize_i, // ahb size
	input wire logic [31:0] hwdata_i, // ahb write data
	input wire logic hready_i, // ahb bus ready
	output logic [31:0] hrdata_o, // ahb read data
	output logic hreadyout_o, // ahb slave ready
	output logic hresp_o, // ahb response, always okay
	input wire logic comp_i, // comparator decision
	output logic [RES_W-1:0] dac_code_o, // resistor-string code
	output sas_pkg::sas_chan_t chan_sel_o, // mux select code
	output logic chan_en_o, // external pin routed
	output logic bandgap_en_o, // bandgap routed
	output logic conv_busy_o, // conversion in progress
	output logic irq_o // enabled event pending
);
	import sas_pkg::*;

	if (RES_W != 12 || AW < 10) begin : g_bad
		$error("sas_adc_ctrl: result split needs RES_W 12, AW >= 10");
	end

	// ------------------------------------------------------------
	// ahb-lite slave: zero wait, data phase one cycle later
	// ------------------------------------------------------------
	logic acc;
	logic dp_wr_r;
	logic [7:0] dp_idx_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_nxt;
	logic [7:0] wdat;
	logic wr_mode;
	logic wr_en;
	logic wr_clr;

	// only whole aligned words are taken; other sizes act as no-op
	assign acc = hsel_i && htrans_i[1] && hready_i &&
		(hsize_i == 3'b010) && (haddr_i[1:0] == 2'b00);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dp_wr_r <= 1'b0;
			dp_idx_r <= 8'h00;
		end else begin
			dp_wr_r <= acc && hwrite_i;
			dp_idx_r <= haddr_i[9:2];
		end
	end

	assign wdat = hwdata_i[7:0];
	assign wr_mode = dp_wr_r && (dp_idx_r == `SAS_MODE_IDX);
	assign wr_en = dp_wr_r && (dp_idx_r == `SAS_EV_EN_IDX);
	assign wr_clr = dp_wr_r && (dp_idx_r == `SAS_EV_CLR_IDX);

	// ------------------------------------------------------------
	// mode register
	// ------------------------------------------------------------
	logic start_r;
	logic done_r;
	sas_clk_sel_t clk_sel_r;
	sas_chan_t chan_r;
	logic seq_busy;
	logic seq_done;
	logic seq_start;
	logic seq_abort;
	logic [RES_W-1:0] seq_sar;

	// a start write while busy leaves the running conversion alone
	assign seq_start = wr_mode && wdat[`SAS_START_BIT] &&
		!seq_busy && !seq_done;
	assign seq_abort = wr_mode && !wdat[`SAS_START_BIT] && seq_busy;

	// start bit: completion wins over a write in the same cycle
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			start_r <= 1'(`SAS_MODE_RST >> `SAS_START_BIT);
		end else if (seq_done) begin
			start_r <= 1'b0;
		end else if (wr_mode) begin
			start_r <= wdat[`SAS_START_BIT];
		end
	end

	// done flag: hardware set, cleared only by a new start
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_r <= 1'b0;
		end else if (seq_done) begin
			done_r <= 1'b1;
		end else if (seq_start) begin
			done_r <= 1'b0;
		end
	end

	// clock and channel fields, writable at any time
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clk_sel_r <= 2'h0;
			chan_r <= 4'h0;
		end else if (wr_mode) begin
			clk_sel_r <= wdat[`SAS_CLK_MSB:`SAS_CLK_LSB];
			chan_r <= wdat[`SAS_CHAN_MSB:`SAS_CHAN_LSB];
		end
	end

	// ------------------------------------------------------------
	// converter clock divider, restarted with each conversion
	// ------------------------------------------------------------
	logic [2:0] div_cnt_r;
	logic [2:0] div_mask;
	logic tick;

	assign div_mask = 3'((4'h1 << clk_sel_r) - 4'h1);
	assign tick = ((div_cnt_r & div_mask) == div_mask);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_r <= 3'h0;
		end else if (seq_start) begin
			div_cnt_r <= 3'h0;
		end else begin
			div_cnt_r <= div_cnt_r + 3'h1;
		end
	end

	sas_sar_seq #(
		.RES_W(RES_W)
	) u_seq (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.start_i(seq_start),
		.abort_i(seq_abort),
		.comp_i(comp_i),
		.busy_o(seq_busy),
		.done_o(seq_done),
		.sar_o(seq_sar),
		.dac_code_o(dac_code_o)
	);

	// ------------------------------------------------------------
	// result registers, read-only, updated only at completion
	// ------------------------------------------------------------
	logic [RES_W-1:0] res_r;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			res_r <= '0;
		end else if (seq_done) begin
			res_r <= seq_sar;
		end
	end

	// ------------------------------------------------------------
	// events: sticky status, enable, write-one-to-clear
	// ------------------------------------------------------------
	logic [`SAS_EV_W-1:0] ev_stat_r;
	logic [`SAS_EV_W-1:0] ev_en_r;
	logic [`SAS_EV_W-1:0] ev_set;
	logic too_fast;

	// conversion time shorter than the analog minimum
	assign too_fast = seq_start && (int'(`SAS_TOTAL_CLKS) <<
		wdat[`SAS_CLK_MSB:`SAS_CLK_LSB]) < `SAS_MIN_CONV_CYC;
	assign ev_set = {too_fast, seq_abort, seq_done};

	// set wins over a clear landing in the same cycle
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ev_stat_r <= '0;
		end else begin
			ev_stat_r <= (ev_stat_r &
				~(wr_clr ? wdat[`SAS_EV_W-1:0] : '0)) | ev_set;
		end
	end

	// enables reset to zero, so completion alone raises no request
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ev_en_r <= '0;
		end else if (wr_en) begin
			ev_en_r <= wdat[`SAS_EV_W-1:0];
		end
	end

	assign irq_o = |(ev_stat_r & ev_en_r);

	// ------------------------------------------------------------
	// read path: registered in the address phase
	// ------------------------------------------------------------
	// a read right behind a write sees the old value; single
	// transfers with an idle data phase never hit this
	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (haddr_i[9:2])
			`SAS_MODE_IDX: rd_nxt[7:0] = {start_r, done_r, clk_sel_r, chan_r};
			`SAS_RES_HI_IDX: rd_nxt[7:0] = res_r[11:4];
			`SAS_RES_LO_IDX: rd_nxt[3:0] = res_r[3:0];
			`SAS_EV_STAT_IDX: rd_nxt[`SAS_EV_W-1:0] = ev_stat_r;
			`SAS_EV_EN_IDX: rd_nxt[`SAS_EV_W-1:0] = ev_en_r;
			default: rd_nxt = 32'h0000_0000; // unmapped and clear read 0
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hrdata_r <= 32'h0000_0000;
		end else if (acc && !hwrite_i) begin
			hrdata_r <= rd_nxt;
		end
	end

	assign hrdata_o = hrdata_r;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// ------------------------------------------------------------
	// analog side: one route at a time
	// ------------------------------------------------------------
	assign chan_sel_o = chan_r;
	assign chan_en_o = sas_chan_ext(chan_r);
	assign bandgap_en_o = (chan_r == `SAS_CHAN_BANDGAP);
	assign conv_busy_o = seq_busy;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_start_wr;
		wr_mode && wdat[`SAS_START_BIT] && !seq_busy && !seq_done;
	endsequence

	sequence s_running;
		start_r && !done_r && seq_busy;
	endsequence

	property p_done_clr;
		s_start_wr |=> s_running;
	endproperty
	a_done_clr: assert property (p_done_clr)
		else $error("start did not clear done");

	property p_done_set;
		seq_done |=> done_r && !start_r && !seq_busy;
	endproperty
	a_done_set: assert property (p_done_set)
		else $error("completion did not set done and clear start");

	property p_stop;
		wr_mode && !wdat[`SAS_START_BIT] && seq_busy
			|=> !seq_busy && !start_r && !done_r;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop write did not halt the conversion");

	property p_div8;
		tick && clk_sel_r == 2'b11 |=>
			(!tick || clk_sel_r != 2'b11) [*7];
	endproperty
	a_div8: assert property (p_div8)
		else $error("divide by 8 ticked too early");

	property p_route;
		$onehot0({chan_en_o, bandgap_en_o}) &&
			(chan_en_o == sas_chan_ext(chan_sel_o));
	endproperty
	a_route: assert property (p_route)
		else $error("channel routing wrong");

	property p_chan_wr;
		wr_mode |=> chan_sel_o == $past(wdat[3:0]);
	endproperty
	a_chan_wr: assert property (p_chan_wr)
		else $error("channel rewrite not applied");

	property p_result;
		seq_done |=> res_r == $past(seq_sar);
	endproperty
	a_result: assert property (p_result)
		else $error("result not stored at completion");

	property p_hold;
		!seq_done |=> $stable(res_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("result changed without completion");

	property p_low_read;
		acc && !hwrite_i && haddr_i[9:2] == `SAS_RES_LO_IDX
			|=> hrdata_o == {28'h0000000, $past(res_r[3:0])};
	endproperty
	a_low_read: assert property (p_low_read)
		else $error("low result read wrong");

	property p_no_irq;
		ev_en_r == '0 && !wr_en |=> !irq_o;
	endproperty
	a_no_irq: assert property (p_no_irq)
		else $error("interrupt raised with events disabled");
endmodule // sas_adc_ctrl

// >>> verif/sas_analog_model.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// analog side: input mux, resistor string and comparator
// ------------------------------------------------------------
module sas_analog_model (
	input wire logic ref_clk_i, // system clock
	input wire logic [11:0] dac_code_i, // trial code from sequencer
	input wire logic [3:0] chan_sel_i, // mux select code
	input wire logic chan_en_i, // external pin routed
	input wire logic bandgap_en_i, // bandgap routed
	input wire logic [15:0][11:0] level_i, // level of each input
	output logic comp_o // input above trial code
);
	logic flip_r = 1'b0;
	logic [11:0] lvl;

	// one input reaches the comparator, picked by the select code
	assign lvl = level_i[chan_sel_i];

	// open comparator input has no stable decision, so it wanders
	always_ff @(posedge ref_clk_i) begin
		flip_r <= ~flip_r;
	end

	// a level sits half a step above its code: ideal result is the code
	always_comb begin
		if (chan_en_i || bandgap_en_i) begin
			comp_o = (lvl >= dac_code_i);
		end else begin
			comp_o = flip_r;
		end
	end
endmodule // sas_analog_model

// >>> verif/sar_adc_sequencer_test.sv
`timescale 1ns/1ns
`include "sas_map.svh"

module sar_adc_sequencer_test;
	import sas_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [9:0] haddr = 10'h000;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic comp;
	logic [11:0] dac;
	sas_chan_t chan_sel;
	logic chan_en;
	logic bg_en;
	logic busy;
	logic irq;
	logic [15:0][11:0] level = '0;
	logic [31:0] last_hi = 32'h0;
	int busy_cnt = 0;
	int error_cnt = 0;
	int checks_done = 0;

	sas_adc_ctrl i_dut (
		.ref_clk_i(ref_clk), .rst_i(rst), .hsel_i(hsel),
		.haddr_i(haddr), .hwrite_i(hwrite), .htrans_i(htrans),
		.hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.comp_i(comp), .dac_code_o(dac), .chan_sel_o(chan_sel),
		.chan_en_o(chan_en), .bandgap_en_o(bg_en),
		.conv_busy_o(busy), .irq_o(irq)
	);

	sas_analog_model i_ana (
		.ref_clk_i(ref_clk), .dac_code_i(dac), .chan_sel_i(chan_sel),
		.chan_en_i(chan_en), .bandgap_en_i(bg_en), .level_i(level),
		.comp_o(comp)
	);

	// clock and busy-cycle counter for conversion length
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (busy === 1'b1)
			busy_cnt <= busy_cnt + 1;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// single word transfer; holds each phase until hready is seen
	task automatic bus(input logic wr, input logic [7:0] idx,
			input logic [31:0] wd, output logic [31:0] rd_d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge ref_clk); while (hready !== 1'b1);
		rd_d = hrdata;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] dummy;
		bus(1'b1, idx, wd, dummy);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [31:0] rd_d);
		bus(1'b0, idx, 32'h0, rd_d);
	endtask

	function automatic logic [31:0] mode(input logic st,
			input logic [1:0] sel, input logic [3:0] ch);
		mode = {24'h0, st, 1'b0, sel, ch};
	endfunction

	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		rd(`SAS_MODE_IDX, d);
		check("mode after reset", d, 32'h0);
		check("busy after reset", {31'h0, busy}, 32'h0);
		check("hready after reset", {31'h0, hready}, 32'h1);
		check("hresp okay", {31'h0, hresp}, 32'h0);
		rd(8'h10, d);
		check("unmapped read", d, 32'h0);
	endtask

	// every select code, routing flags worked out by hand
	task automatic t_chan();
		logic [31:0] d;
		for (int c = 0; c < 16; c++) begin
			wr(`SAS_MODE_IDX, mode(1'b0, 2'h0, c[3:0]));
			@(negedge ref_clk);
			check("chan_sel", {28'h0, chan_sel}, c);
			check("pin route", {31'h0, chan_en}, (c <= 8 || c == 14));
			check("bandgap route", {31'h0, bg_en}, (c == 15));
		end
		rd(`SAS_MODE_IDX, d);
		check("mode readback", d, 32'h0F);
	endtask

	task automatic t_conv(input logic [1:0] sel, input logic [3:0] ch,
			input logic [11:0] lv);
		logic [31:0] d;
		int b0;
		int div;
		int n;
		level[ch] <= lv;
		div = 1 << sel;
		b0 = busy_cnt;
		wr(`SAS_MODE_IDX, mode(1'b1, sel, ch));
		@(negedge ref_clk);
		check("busy at start", {31'h0, busy}, 32'h1);
		rd(`SAS_MODE_IDX, d);
		check("start set done clear", {30'h0, d[7:6]}, 32'h2);
		n = 0;
		while (dac === 12'h000 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		check("first trial", {20'h0, dac}, 32'h800);
		do rd(`SAS_MODE_IDX, d); while (d[6] !== 1'b1);
		check("done set start clear", {30'h0, d[7:6]}, 32'h1);
		n = busy_cnt - b0;
		check("conv length", (n >= 65 * div + 1 && n <= 66 * div + 2), 1);
		check("no irq", {31'h0, irq}, 32'h0);
		last_hi = {24'h0, lv[11:4]};
		rd(`SAS_RES_HI_IDX, d);
		check("result high", d, last_hi);
		rd(`SAS_RES_LO_IDX, d);
		check("result low", d, {28'h0, lv[3:0]});
	endtask

	// events, masking, abort and read-only results
	task automatic t_events();
		logic [31:0] d;
		rd(`SAS_EV_STAT_IDX, d);
		check("done and fast events", d, 32'h5);
		wr(`SAS_EV_EN_IDX, 32'h2);
		@(negedge ref_clk);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr(`SAS_MODE_IDX, mode(1'b1, 2'h3, 4'h2));
		repeat (20) @(posedge ref_clk);
		wr(`SAS_MODE_IDX, mode(1'b0, 2'h3, 4'h2));
		@(negedge ref_clk);
		check("busy after stop", {31'h0, busy}, 32'h0);
		check("abort irq", {31'h0, irq}, 32'h1);
		rd(`SAS_MODE_IDX, d);
		check("no done on stop", {30'h0, d[7:6]}, 32'h0);
		wr(`SAS_RES_HI_IDX, 32'hFF);
		rd(`SAS_RES_HI_IDX, d);
		check("result held", d, last_hi);
		wr(`SAS_EV_CLR_IDX, 32'h7);
		@(negedge ref_clk);
		check("irq cleared", {31'h0, irq}, 32'h0);
		rd(`SAS_EV_STAT_IDX, d);
		check("status cleared", d, 32'h0);
		wr(`SAS_EV_EN_IDX, 32'h0);
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_chan();
		t_conv(2'h0, 4'h0, 12'hA5C);
		t_conv(2'h1, 4'hE, 12'h3E1);
		t_conv(2'h2, 4'hF, 12'hFFF);
		t_conv(2'h3, 4'h8, 12'h001);
		t_events();
		end_sim();
	end

	// whole run is near 1200 cycles; over sixteen times that means a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		end_sim();
	end
endmodule // sar_adc_sequencer_test
